//--- sofs_nv_model.sv
/*
  Non-volatile image of the two selector words for the bench.
  Assumes commit pulses are synchronous to mclk.
*/
module sofs_nv_model
  import sofs_pkg::*;
(
  input  wire logic      mclk,       // System clock
  input  wire logic      nv_wr,      // Commit pulse
  input  wire logic      nv_wr_idx,  // Selector index
  input  wire sofs_sel_t nv_wr_data, // Committed value
  output sofs_sel_t      nv_image0,  // Stored word 0
  output sofs_sel_t      nv_image1   // Stored word 1
);
  timeunit 1ns;
  timeprecision 1ps;

  // Blank image so the first boot falls back to factory defaults
  initial
  begin
    nv_image0 = 16'h0000;
    nv_image1 = 16'h0000;
  end

  // survives power-on
  // No reset input: the words must outlive srst like flash does
  always @(posedge mclk)
  begin
    if (nv_wr && !nv_wr_idx)
      nv_image0 <= nv_wr_data;
    if (nv_wr && nv_wr_idx)
      nv_image1 <= nv_wr_data;
  end
endmodule : sofs_nv_model

//--- sofs_pkg.sv
/*
  Shared constants and types for the status output function selector:
  parameter addresses, selector codes, factory defaults, the condition
  carrier and the parameter access request and response carriers.
  Assumes one synchronous clock domain; no other package is needed.
*/
package sofs_pkg;

  // Parameter addresses on the access port, as printed
  localparam logic [15:0] SOFS_ADDR_OUT0 = 16'h0712;
  localparam logic [15:0] SOFS_ADDR_OUT1 = 16'h0714;

  // Selector codes
  localparam logic [15:0] SOFS_CODE_FREE       = 16'h0001;
  localparam logic [15:0] SOFS_CODE_NO_FAULT   = 16'h0002;
  localparam logic [15:0] SOFS_CODE_ACTIVE     = 16'h0003;
  localparam logic [15:0] SOFS_CODE_CAP_MOVE   = 16'h0004;
  localparam logic [15:0] SOFS_CODE_POS_WIN    = 16'h0005;
  localparam logic [15:0] SOFS_CODE_VEL_WIN    = 16'h0006;
  localparam logic [15:0] SOFS_CODE_VEL_BELOW  = 16'h0007;
  localparam logic [15:0] SOFS_CODE_CUR_BELOW  = 16'h0008;
  localparam logic [15:0] SOFS_CODE_HALT_ACK   = 16'h0009;
  localparam logic [15:0] SOFS_CODE_MSEQ_START = 16'h000B;
  localparam logic [15:0] SOFS_CODE_STANDSTILL = 16'h000D;
  localparam logic [15:0] SOFS_CODE_SEL_ERROR  = 16'h000E;
  localparam logic [15:0] SOFS_CODE_REF_OK     = 16'h000F;
  localparam logic [15:0] SOFS_CODE_SEL_WARN   = 16'h0010;
  localparam logic [15:0] SOFS_CODE_MSEQ_DONE  = 16'h0011;
  localparam logic [15:0] SOFS_CODE_POSREG1    = 16'h0012;
  localparam logic [15:0] SOFS_CODE_POSREG2    = 16'h0013;
  localparam logic [15:0] SOFS_CODE_POSREG3    = 16'h0014;
  localparam logic [15:0] SOFS_CODE_POSREG4    = 16'h0015;
  localparam logic [15:0] SOFS_CODE_MOVES_NEG  = 16'h0016;

  // Factory defaults
  localparam logic [15:0] SOFS_DFLT_OUT0       = SOFS_CODE_NO_FAULT;
  localparam logic [15:0] SOFS_DFLT_OUT1       = SOFS_CODE_ACTIVE;
  localparam logic [15:0] SOFS_DFLT_OUT0_MSEQ  = SOFS_CODE_MSEQ_START;

  // Reset values of the held selector copies before the image is read, and of the read and commit data
  localparam logic [15:0] SOFS_SEL_RST         = 16'h0000;
  localparam logic [15:0] SOFS_DATA_RST        = 16'h0000;

  typedef logic [15:0] sofs_sel_t;

  typedef enum logic [0:0] {
    SOFS_BOOT,
    SOFS_RUN
  } sofs_state_e;

  // Drive conditions produced elsewhere in the drive
  typedef struct packed {
    logic       rdy_to_switch_on; // State ready to switch on
    logic       switched_on;      // State switched on
    logic       op_enabled;       // State operation enabled
    logic       cap_move;         // Relative move after capture busy/done
    logic       pos_dev_in_win;   // Position deviation in window
    logic       vel_dev_in_win;   // Velocity deviation in window
    logic       vel_below;        // Velocity below threshold
    logic       cur_below;        // Current below threshold
    logic       halt_ack;         // Halt acknowledge
    logic       mseq_start_ack;   // Motion sequence start acknowledge
    logic       standstill;       // Motor at standstill
    logic       sel_error;        // Configured class 1..4 error active
    logic       ref_ok;           // Homing zero point valid
    logic       sel_warning;      // Configured class 0 warning active
    logic       mseq_done;        // Motion sequence finished
    logic [3:0] posreg;           // Position register channels 1..4
    logic       moves_neg;        // Motor moves in negative direction
  } sofs_cond_s;

  typedef struct packed {
    logic      valid;             // Request present
    logic      write;             // 1 write, 0 read
    logic [15:0] addr;            // Parameter address
    sofs_sel_t wdata;             // Write data
  } sofs_req_s;

  typedef struct packed {
    logic      ack;               // Request done
    logic      err;               // Request refused
    sofs_sel_t rdata;             // Read data
  } sofs_rsp_s;

  // Code defined and offered in the current control and operating mode
  function automatic logic sofs_code_ok(input sofs_sel_t code,
                                        input logic      fieldbus,
                                        input logic      mseq);
    logic ok;
    ok = 1'b0;
    if ((code >= SOFS_CODE_FREE) && (code <= SOFS_CODE_STANDSTILL))
      ok = (code != 16'h000A) && (code != 16'h000C);
    else if ((code >= SOFS_CODE_SEL_ERROR) && (code <= SOFS_CODE_MOVES_NEG))
      ok = 1'b1;
    if (!fieldbus && !mseq)
      if ((code == SOFS_CODE_MSEQ_START) || (code == SOFS_CODE_REF_OK) ||
          ((code >= SOFS_CODE_MSEQ_DONE) && (code <= SOFS_CODE_POSREG4)))
        ok = 1'b0;
    if (fieldbus)
      if ((code == SOFS_CODE_MSEQ_START) || (code == SOFS_CODE_MSEQ_DONE))
        ok = 1'b0;
    return ok;
  endfunction : sofs_code_ok

  // Factory default for an output in the given mode
  function automatic sofs_sel_t sofs_default(input logic idx,
                                             input logic fieldbus,
                                             input logic mseq);
    sofs_sel_t d;
    d = idx ? SOFS_DFLT_OUT1 : SOFS_DFLT_OUT0;
    if (!idx && !fieldbus && mseq)
      d = SOFS_DFLT_OUT0_MSEQ;
    return d;
  endfunction : sofs_default

endpackage : sofs_pkg

//--- sofs_properties.sv
/*
  Checker for the status output selector: port answers, write lock,
  commit and routing of both outputs.
  Assumes it is bound to sofs_top; cycles with ce low are judged only by routing_hold_a and commit_cause_a.
*/
module sofs_properties
  import sofs_pkg::*;
#(
  parameter int NUM_OUT = 2  // Number of status outputs
)
(
  input wire logic       mclk,               // System clock
  input wire logic       srst,               // Synchronous reset
  input wire logic       ce,                 // Clock enable
  input wire logic       power_stage_on,     // Power stage enabled
  input wire sofs_cond_s cond,               // Drive conditions
  input wire logic [1:0] free_val,           // Software levels
  input wire sofs_req_s  req,                // Access request
  input wire sofs_rsp_s  rsp,                // Access response
  input wire logic       nv_wr,              // Commit pulse
  input wire logic       nv_wr_idx,          // Committed selector
  input wire sofs_sel_t  nv_wr_data,         // Committed value
  input wire sofs_sel_t  active_sel0,        // Routing code 0
  input wire sofs_sel_t  active_sel1,        // Routing code 1
  input wire logic       status_output_zero, // Output 0
  input wire logic       status_output_one   // Output 1
);
  timeunit 1ns;
  timeprecision 1ps;

  logic exp0; // Level due on output 0
  logic exp1; // Level due on output 1

  // Bit k is the level for code k; gaps stay dead at 0
  function automatic logic lvl(input sofs_sel_t s, input sofs_cond_s c,
                               input logic f);
    logic [22:0] v;
    v = {c.moves_neg, c.posreg, c.mseq_done, c.sel_warning, c.ref_ok,
         c.sel_error, c.standstill, 1'b0, c.mseq_start_ack, 1'b0,
         c.halt_ack, c.cur_below, c.vel_below, c.vel_dev_in_win,
         c.pos_dev_in_win, c.cap_move, c.op_enabled,
         c.rdy_to_switch_on | c.switched_on | c.op_enabled, f, 1'b0};
    return (s <= 16'h0016) ? v[s[4:0]] : 1'b0;
  endfunction : lvl

  // Expected levels from the live codes
  assign exp0 = lvl(active_sel0, cond, free_val[0]);
  assign exp1 = lvl(active_sel1, cond, free_val[1]);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // Steps of a request and of an accepted write
  sequence req_taken;
    ce && req.valid;
  endsequence
  sequence wr_taken;
    ce && req.valid && req.write ##1 rsp.ack;
  endsequence

  answer_once_a: assert property (req_taken |=> rsp.ack != rsp.err)
    else $error("request not answered by one of ack and err");
  idle_quiet_a: assert property (
    ce && !req.valid |=> !rsp.ack && !rsp.err)
    else $error("answer without a request");
  stage_lock_a: assert property (
    req_taken ##0 req.write && power_stage_on |=> rsp.err && !nv_wr)
    else $error("write taken while power stage on");
  commit_data_a: assert property (wr_taken |-> nv_wr &&
    nv_wr_data == $past(req.wdata) &&
    nv_wr_idx == ($past(req.addr) == SOFS_ADDR_OUT1))
    else $error("accepted write not committed as sent");
  commit_cause_a: assert property (
    nv_wr |-> rsp.ack && $past(req.valid) && $past(req.write))
    else $error("commit without accepted write");
  routing_hold_a: assert property (
    !$past(srst) && !$past(srst, 2) |->
      $stable(active_sel0) && $stable(active_sel1))
    else $error("routing code changed without power-on");
  route_zero_a: assert property (
    $past(ce) |-> status_output_zero == $past(exp0))
    else $error("output 0 does not follow its selected source");
  route_one_a: assert property (
    $past(ce) |-> status_output_one == $past(exp1))
    else $error("output 1 does not follow its selected source");
endmodule : sofs_properties

bind sofs_top sofs_properties #(.NUM_OUT(NUM_OUT)) i_sofs_properties (
  .mclk(mclk), .srst(srst), .ce(ce), .power_stage_on(power_stage_on),
  .cond(cond), .free_val(free_val), .req(req), .rsp(rsp),
  .nv_wr(nv_wr), .nv_wr_idx(nv_wr_idx), .nv_wr_data(nv_wr_data),
  .active_sel0(active_sel0), .active_sel1(active_sel1),
  .status_output_zero(status_output_zero),
  .status_output_one(status_output_one));

//--- sofs_route.sv
/*
  One output router: maps the active selector code onto a drive condition
  and registers the pin level.
  Assumes the code was validated before it became active.
*/
module sofs_route
  import sofs_pkg::*;
(
  input  wire logic       mclk,     // System clock
  input  wire logic       srst,     // Synchronous reset, high
  input  wire logic       ce,       // Clock enable
  input  wire logic       run,      // Routing live after power-on load
  input  wire sofs_sel_t  sel,      // Active selector code
  input  wire sofs_cond_s cond,     // Drive conditions
  input  wire logic       free_val, // Software value for free output
  output logic            level     // Registered output level
);

  logic level_nxt;

  // Source selection; no error override, outputs keep their function
  // no error forcing
  always_comb
  begin
    level_nxt = 1'b0;
    case (sel)
      SOFS_CODE_FREE       : level_nxt = free_val;
      SOFS_CODE_NO_FAULT   : level_nxt = cond.rdy_to_switch_on |
                                         cond.switched_on | cond.op_enabled;
      SOFS_CODE_ACTIVE     : level_nxt = cond.op_enabled;
      SOFS_CODE_CAP_MOVE   : level_nxt = cond.cap_move;
      SOFS_CODE_POS_WIN    : level_nxt = cond.pos_dev_in_win;
      SOFS_CODE_VEL_WIN    : level_nxt = cond.vel_dev_in_win;
      SOFS_CODE_VEL_BELOW  : level_nxt = cond.vel_below;
      SOFS_CODE_CUR_BELOW  : level_nxt = cond.cur_below;
      SOFS_CODE_HALT_ACK   : level_nxt = cond.halt_ack;
      SOFS_CODE_MSEQ_START : level_nxt = cond.mseq_start_ack;
      SOFS_CODE_STANDSTILL : level_nxt = cond.standstill;
      SOFS_CODE_SEL_ERROR  : level_nxt = cond.sel_error;
      SOFS_CODE_REF_OK     : level_nxt = cond.ref_ok;
      SOFS_CODE_SEL_WARN   : level_nxt = cond.sel_warning;
      SOFS_CODE_MSEQ_DONE  : level_nxt = cond.mseq_done;
      SOFS_CODE_POSREG1    : level_nxt = cond.posreg[0];
      SOFS_CODE_POSREG2    : level_nxt = cond.posreg[1];
      SOFS_CODE_POSREG3    : level_nxt = cond.posreg[2];
      SOFS_CODE_POSREG4    : level_nxt = cond.posreg[3];
      SOFS_CODE_MOVES_NEG  : level_nxt = cond.moves_neg;
      default              : level_nxt = 1'b0;
    endcase
  end

  // Pin register; held low until the power-on load has finished
  always_ff @(posedge mclk)
  begin
    if (srst)
      level <= 1'b0;
    else if (ce)
      level <= run ? level_nxt : 1'b0;
  end

endmodule : sofs_route

//--- sofs_top.sv
/*
  Status output function selector: two persistent 16-bit selectors
  reached over a simple parameter access port, a power-on load from the
  non-volatile image, write commit toward that image, and two routers
  driving the digital status outputs.
  Assumes the non-volatile image is presented steadily on nv_image0/1
  from reset onward, and that condition inputs are synchronous to mclk.
*/
// Behaviour
// - Two persistent readable writable 16-bit selectors, one per output.
// - Code 1 drives the output from a software value only.
// - Code 2 asserts in ready-to-switch-on, switched-on or operation-enabled.
// - Code 3 asserts only in operation-enabled.
// - Code 4 asserts while a relative move after capture runs or finished.
// - Codes 5 and 6 assert inside position and velocity deviation windows.
// - Codes 7 and 8 assert for velocity and current below threshold.
// - Code 9 routes the halt acknowledgement.
// - Code 11 routes the motion sequence start acknowledgement.
// - Code 13 asserts while the motor stands still.
// - Code 14 asserts while a configured class one to four error is active.
// - Code 15 asserts while the homing zero point is valid.
// - Code 16 asserts while a configured class zero warning is active.
// - Code 17 asserts when the motion sequence has finished.
// - Codes 18 to 21 route position register channels one to four.
// - Selector writes accepted only while the power stage is disabled.
// - New values are stored but routing changes only at next power-on.
// - On an error each output keeps following its assigned function.
// - Fieldbus default: output zero no fault, output one active.
module sofs_top
  import sofs_pkg::*;
#(
  parameter int NUM_OUT = 2                 // Number of status outputs
)
(
  input  wire logic       mclk,             // System clock, 100 MHz
  input  wire logic       srst,             // Synchronous reset, power-on
  input  wire logic       ce,               // Clock enable
  input  wire logic       fieldbus_mode,    // 1 fieldbus, 0 local control
  input  wire logic       mseq_mode,        // Local: motion sequence mode
  input  wire logic       power_stage_on,   // Power stage enabled
  input  wire sofs_sel_t  nv_image0,        // Stored selector, output 0
  input  wire sofs_sel_t  nv_image1,        // Stored selector, output 1
  input  wire sofs_cond_s cond,             // Drive conditions
  input  wire logic [1:0] free_val,         // Software level, free outputs
  input  wire sofs_req_s  req,              // Parameter access request
  output sofs_rsp_s       rsp,              // Parameter access response
  output logic            nv_wr,            // Commit pulse to image
  output logic            nv_wr_idx,        // Selector being committed
  output sofs_sel_t       nv_wr_data,       // Value being committed
  output sofs_sel_t       active_sel0,      // Routing code, output 0
  output sofs_sel_t       active_sel1,      // Routing code, output 1
  output logic            status_output_zero, // Digital status output 0
  output logic            status_output_one   // Digital status output 1
);

  localparam int IDX_W = (NUM_OUT > 1) ? $clog2(NUM_OUT) : 1;

  sofs_state_e state_r;
  sofs_state_e state_nxt;

  // Stored values read back over the port, and the routing copies
  sofs_sel_t   stored_r [NUM_OUT];
  sofs_sel_t   active_r [NUM_OUT];
  sofs_sel_t   image    [NUM_OUT];
  logic [NUM_OUT-1:0] levels;

  // Decoded request
  logic        hit;
  logic [IDX_W-1:0] hit_idx;
  logic        wr_ok;
  logic        rd_ok;
  logic        take;

  // Response registers
  logic        ack_r;
  logic        err_r;
  sofs_sel_t   rdata_r;
  logic        nv_wr_r;
  logic [IDX_W-1:0] nv_wr_idx_r;
  sofs_sel_t   nv_wr_data_r;

  assign image[0] = nv_image0;
  assign image[1] = nv_image1;

  // A request is only looked at in a live cycle
  assign take = ce && req.valid;

  // Address decode of the two selector parameters
  always_comb
  begin
    hit     = 1'b0;
    hit_idx = '0;
    if (req.addr == SOFS_ADDR_OUT0)
    begin
      hit     = 1'b1;
      hit_idx = IDX_W'(0);
    end
    else if (req.addr == SOFS_ADDR_OUT1)
    begin
      hit     = 1'b1;
      hit_idx = IDX_W'(1);
    end
  end

  // Acceptance terms; boot refuses everything so the image load is clean
  // power stage interlock
  assign wr_ok = (state_r == SOFS_RUN) && hit && req.write &&
                 !power_stage_on &&
                 sofs_code_ok(req.wdata, fieldbus_mode, mseq_mode);
  assign rd_ok = (state_r == SOFS_RUN) && hit && !req.write;

  // Power-on sequence: one live cycle to load the image, then run
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SOFS_BOOT : state_nxt = SOFS_RUN;
      SOFS_RUN  : state_nxt = SOFS_RUN;
      default   : state_nxt = SOFS_BOOT;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      state_r <= SOFS_BOOT;
    else if (ce)
      state_r <= state_nxt;
  end

  // Stored selectors: image at power-on, then accepted writes.
  // An image word that is not a valid code falls back to the factory
  // default, so a blank or corrupt store never leaves a pin unrouted.
  // persistent selectors
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NUM_OUT; i++)
        stored_r[i] <= SOFS_SEL_RST;
    end
    else if (ce)
    begin
      if (state_r == SOFS_BOOT)
      begin
        for (int i = 0; i < NUM_OUT; i++)
          if (sofs_code_ok(image[i], fieldbus_mode, mseq_mode))
            stored_r[i] <= image[i];
          else
            stored_r[i] <= sofs_default(i[0], fieldbus_mode, mseq_mode);
      end
      else if (take && wr_ok)
        stored_r[hit_idx] <= req.wdata;
    end
  end

  // Routing copies change only in the power-on load cycle; a write
  // while running lands in the store and waits for the next power-on.
  // change at next power-on
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NUM_OUT; i++)
        active_r[i] <= SOFS_SEL_RST;
    end
    else if (ce && (state_r == SOFS_BOOT))
    begin
      for (int i = 0; i < NUM_OUT; i++)
        if (sofs_code_ok(image[i], fieldbus_mode, mseq_mode))
          active_r[i] <= image[i];
        else
          active_r[i] <= sofs_default(i[0], fieldbus_mode, mseq_mode);
    end
  end

  // Access response, one cycle after the request is taken.
  // While ce is low the pulse holds; the requester must see ce too.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= SOFS_DATA_RST;
    end
    else if (ce)
    begin
      ack_r <= take && (wr_ok || rd_ok);
      err_r <= take && !(wr_ok || rd_ok);
      if (take && rd_ok)
        rdata_r <= stored_r[hit_idx];
    end
  end

  // Commit of an accepted write toward the non-volatile image
  // persistent store commit
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      nv_wr_r      <= 1'b0;
      nv_wr_idx_r  <= '0;
      nv_wr_data_r <= SOFS_DATA_RST;
    end
    else if (ce)
    begin
      nv_wr_r <= take && wr_ok;
      if (take && wr_ok)
      begin
        nv_wr_idx_r  <= hit_idx;
        nv_wr_data_r <= req.wdata;
      end
    end
  end

  // One router per output, each fed by its own routing copy
  for (genvar g = 0; g < NUM_OUT; g++)
  begin : g_route
    sofs_route u_route (
      .mclk     (mclk),
      .srst     (srst),
      .ce       (ce),
      .run      (state_r == SOFS_RUN),
      .sel      (active_r[g]),
      .cond     (cond),
      .free_val (free_val[g]),
      .level    (levels[g])
    );
  end

  // Output assignments
  assign rsp.ack            = ack_r;
  assign rsp.err            = err_r;
  assign rsp.rdata          = rdata_r;
  assign nv_wr              = nv_wr_r;
  assign nv_wr_idx          = nv_wr_idx_r[0];
  assign nv_wr_data         = nv_wr_data_r;
  assign active_sel0        = active_r[0];
  assign active_sel1        = active_r[1];
  assign status_output_zero = levels[0];
  assign status_output_one  = levels[1];

endmodule : sofs_top

//--- status_output_function_select_tb.sv
/*
  Bench for the status output selector: factory defaults, refused
  writes, and every code routed after a power-on.
  Assumes the image model stands in for the non-volatile store.
*/
module status_output_function_select_tb
  import sofs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk, srst, ce, fieldbus_mode, mseq_mode, power_stage_on;
  logic       nv_wr, nv_wr_idx, out0, out1;
  logic [1:0] free_val;
  sofs_sel_t  nv_image0, nv_image1, nv_wr_data, active_sel0, active_sel1;
  sofs_sel_t  q;
  sofs_cond_s cond;
  sofs_req_s  req;
  sofs_rsp_s  rsp;
  int         mismatches;
  int         n_checks;
  // Condition bit per code, -1 where no single bit applies
  int cond_bit[23] = '{-1, -1, 19, 17, 16, 15, 14, 13, 12, 11, -1, 10, -1, 9,
                 8, 7, 6, 5, 1, 2, 3, 4, 0};

  sofs_top #(.NUM_OUT(2)) i_sofs_top (
    .mclk(mclk), .srst(srst), .ce(ce), .fieldbus_mode(fieldbus_mode),
    .mseq_mode(mseq_mode), .power_stage_on(power_stage_on),
    .nv_image0(nv_image0), .nv_image1(nv_image1), .cond(cond),
    .free_val(free_val), .req(req), .rsp(rsp), .nv_wr(nv_wr),
    .nv_wr_idx(nv_wr_idx), .nv_wr_data(nv_wr_data),
    .active_sel0(active_sel0), .active_sel1(active_sel1),
    .status_output_zero(out0), .status_output_one(out1));

  sofs_nv_model i_sofs_nv_model (
    .mclk(mclk), .nv_wr(nv_wr), .nv_wr_idx(nv_wr_idx),
    .nv_wr_data(nv_wr_data), .nv_image0(nv_image0),
    .nv_image1(nv_image1));

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic close_out();
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Power-on: reset, then stop just after the edge that loads the image
  task automatic rst(input int n);
    srst <= 1'b1;
    repeat (n) @(negedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
  endtask : rst

  // One request; valid stays up so calls run back to back
  task automatic acc(input logic w, input logic [15:0] a, d,
                     input logic e);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(negedge mclk);
    chk("ack", rsp.ack, !e);
    chk("err", rsp.err, e);
    q = rsp.rdata;
  endtask : acc

  task automatic t_boot();
    chk("dflt0", active_sel0, SOFS_CODE_NO_FAULT);
    chk("dflt1", active_sel1, SOFS_CODE_ACTIVE);
    fieldbus_mode <= 1'b0;
    mseq_mode <= 1'b1;
    rst(2);
    chk("dflt_mseq", active_sel0, SOFS_CODE_MSEQ_START);
    fieldbus_mode <= 1'b1;
    mseq_mode <= 1'b0;
    rst(2);
  endtask : t_boot

  task automatic t_refuse();
    sofs_sel_t bad[5] = '{16'h0000, 16'h000A, 16'h000C, 16'h0017,
                          16'hFFFF};
    acc(1'b1, SOFS_ADDR_OUT0, SOFS_CODE_POS_WIN, 1'b0);
    chk("active0", active_sel0, SOFS_CODE_NO_FAULT);
    power_stage_on <= 1'b1;
    acc(1'b1, SOFS_ADDR_OUT0, SOFS_CODE_VEL_WIN, 1'b1);
    power_stage_on <= 1'b0;
    acc(1'b0, 16'h0716, 16'h0000, 1'b1);
    foreach (bad[i])
      acc(1'b1, SOFS_ADDR_OUT0, bad[i], 1'b1);
    // Codes not offered in the current mode
    acc(1'b1, SOFS_ADDR_OUT0, SOFS_CODE_MSEQ_DONE, 1'b1);
    fieldbus_mode <= 1'b0;
    acc(1'b1, SOFS_ADDR_OUT0, SOFS_CODE_REF_OK, 1'b1);
    acc(1'b0, SOFS_ADDR_OUT0, 16'h0000, 1'b0);
    req <= '0;
    chk("kept", q, SOFS_CODE_POS_WIN);
    // Clock enable low freezes the port; the request waits for it
    @(negedge mclk);
    ce <= 1'b0;
    req <= '{valid: 1'b1, write: 1'b0, addr: SOFS_ADDR_OUT0,
             wdata: 16'h0000};
    @(negedge mclk);
    chk("ce_hold", rsp.ack, 1'b0);
    ce <= 1'b1;
    @(negedge mclk);
    chk("ce_ack", rsp.ack, 1'b1);
    chk("ce_data", rsp.rdata, SOFS_CODE_POS_WIN);
    req <= '0;
    @(negedge mclk);
  endtask : t_refuse

  task automatic t_codes();
    int b;
    mseq_mode <= 1'b1;
    for (int c = 1; c <= 22; c++)
    begin
      b = cond_bit[c];
      if (c == 10 || c == 12)
        continue;
      acc(1'b1, SOFS_ADDR_OUT0, 16'(c), 1'b0);
      acc(1'b1, SOFS_ADDR_OUT1, 16'(c), 1'b0);
      acc(1'b0, SOFS_ADDR_OUT1, 16'h0000, 1'b0);
      req <= '0;
      chk("readback", q, 16'(c));
      rst(2);
      chk("active0", active_sel0, 16'(c));
      chk("active1", active_sel1, 16'(c));
      // All quiet, then the one source, then all but that source
      cond <= '0;
      free_val <= 2'b01;
      @(negedge mclk);
      chk("zero0", out0, c == 1);
      chk("zero1", out1, 1'b0);
      cond <= sofs_cond_s'((b < 0) ? 20'hFFFFF : 20'h1 << b);
      free_val <= 2'b10;
      @(negedge mclk);
      chk("hot0", out0, c != 1);
      chk("hot1", out1, 1'b1);
      cond <= sofs_cond_s'((b < 0) ? 20'hFFFFF : ~(20'h1 << b));
      free_val <= 2'b00;
      @(negedge mclk);
      chk("rest0", out0, c == 2);
      chk("rest1", out1, c == 2);
    end
  endtask : t_codes

  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    fieldbus_mode = 1'b1;
    mseq_mode = 1'b0;
    power_stage_on = 1'b0;
    cond = '0;
    free_val = 2'b00;
    req = '0;
    mismatches = 0;
    n_checks = 0;
    @(negedge mclk);
    rst(16);
    t_boot();
    t_refuse();
    t_codes();
    close_out();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    #100us;
    mismatches++;
    close_out();
  end
endmodule : status_output_function_select_tb
